// [dsa_params.svh]
`ifndef DSA_PARAMS_SVH
`define DSA_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DSA_OFS_STATUS   8'h00
`define DSA_OFS_RESULT   8'h04
`define DSA_OFS_PRESET   8'h08
`define DSA_OFS_CTRL     8'h0C

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DSA_CTRL_FORCE_BIT  0
`define DSA_RES_OVR_BIT     17
`define DSA_PRESET_RST      8'h80

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define DSA_DIV_LAST     2'h3
`define DSA_FULL_COUNT   17'h10000

`endif

// [dsa_pkg.sv]
package dsa_pkg;

  typedef enum logic [3:0] {
    settle_phase    = 4'h1,
    zeroing_phase   = 4'h2,
    charge_phase    = 4'h4,
    discharge_phase = 4'h8
  } dsa_phase_t;

  typedef struct packed {
    logic shift_strobe;
    logic read_sel_n;
    logic preset_strobe_n;
    logic serial_in;
  } dsa_host_in_t;

  typedef struct packed {
    logic comparator;
    logic conv_allow_n;
  } dsa_fe_in_t;

  typedef struct packed {
    logic phase_a;
    logic phase_b;
  } dsa_phase_out_t;

endpackage : dsa_pkg

// [dsa_ctrl.sv]
`timescale 1ns/1ps
`include "dsa_params.svh"
// Notes on behaviour
// - zeroing and charge last 65536 minus 256 times preset timebase counts
// - preset strobe falling edge loads serial input into preset top bit, rest zero
// - zeroing lasts as many counts as charge, same counter
// - discharge may run up to twice the charge count before overrange
// - timebase is the oscillator divided by four, clocks timer and result
// - power-up in settle with phase outputs zero, wait for comparator change
// - conversions run only while allow input low; otherwise held in zeroing
// - serial output driven only while read select low
// - read select falling edge loads result, overrange and sign into shifter
// - overrange bit shows on serial output at once, no strobe needed
// - each falling shift strobe advances one bit: sign, then 16 bits MSB first
// - strobes past the 18-bit frame shift out zeros
// - conversions continue during read, shifter result not updated until release
// - host may abort a read any time, conversion unaffected
// - shift strobe independent of timebase; each strobe level must last at least one enabled clock to be seen
// - preset shifted in MSB first on rising strobes while preset strobe low
// - result ready goes low once a new result is transferred
// - zeroing phase drives first output 0, second output 1
// - comparator gives polarity and marks the discharge zero crossing
module dsa_ctrl (
  // clock, reset, enable
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  ce,
  // ahb-lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // host serial port
  input  wire dsa_pkg::dsa_host_in_t host_in,
  output logic                       serial_out,
  output logic                       serial_out_oe,
  output logic                       result_ready_n,
  // analog front end
  input  wire dsa_pkg::dsa_fe_in_t   fe_in,
  output dsa_pkg::dsa_phase_out_t    phase_out,
  output logic                       divided_timebase
);
  import dsa_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  dsa_phase_t     state_ff;
  dsa_host_in_t   host_q_ff;
  dsa_phase_out_t phase_out_ff;
  logic [1:0]     div_ff;
  logic [16:0]    timer_ff;
  logic [16:0]    charge_n_ff;
  logic [17:0]    disch_cnt_ff;
  logic [17:0]    result_ff;
  logic [17:0]    out_data_ff;
  logic [17:0]    shreg_ff;
  logic [7:0]     preset_ff;
  logic           comp_tb_ff;
  logic           sign_ff;
  logic           new_ff;
  logic           rdy_n_ff;
  logic           oe_ff;
  logic           ctrl_force_ff;
  logic           wr_pend_ff;
  logic [7:0]     wr_addr_ff;
  logic [31:0]    hrdata_ff;
  logic           hresp_ff;
  logic [15:0]    ph_ticks_ff;
  logic           hreadyout_ff;

  logic           tick;
  logic           force_zero;
  logic           rd_fall;
  logic           sclk_fall;
  logic           sclk_rise;
  logic           load_fall;
  logic [16:0]    nxt_timer;
  logic [17:0]    nxt_disch;
  logic           crossing;
  logic           at_limit;
  logic           run_tick;
  logic           charge_end;
  logic           conv_done;
  logic           xfer;
  logic           ahb_take;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [16:0] dsa_counts(input logic [7:0] p);
    return `DSA_FULL_COUNT - {1'b0, p, 8'h00};
  endfunction : dsa_counts

  function automatic logic [31:0] dsa_read_mux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h00000000;
    if (a == `DSA_OFS_STATUS) begin
      d = {25'h0000000, rdy_n_ff, new_ff, ~host_q_ff.read_sel_n, state_ff};
    end else if (a == `DSA_OFS_RESULT) begin
      d = {14'h0000, out_data_ff};
    end else if (a == `DSA_OFS_PRESET) begin
      d = {24'h000000, preset_ff};
    end else if (a == `DSA_OFS_CTRL) begin
      d = {31'h00000000, ctrl_force_ff};
    end
    return d;
  endfunction : dsa_read_mux

  // host pins are taken as synchronous; one stage of history gives edges
  assign rd_fall    = host_q_ff.read_sel_n & ~host_in.read_sel_n;
  assign sclk_fall  = host_q_ff.shift_strobe & ~host_in.shift_strobe;
  assign sclk_rise  = ~host_q_ff.shift_strobe & host_in.shift_strobe;
  assign load_fall  = host_q_ff.preset_strobe_n & ~host_in.preset_strobe_n;
  assign force_zero = fe_in.conv_allow_n | ~host_in.preset_strobe_n | ctrl_force_ff;

  assign tick       = (div_ff == `DSA_DIV_LAST);
  assign nxt_timer  = timer_ff + 17'h00001;
  assign nxt_disch  = disch_cnt_ff + 18'h00001;
  assign crossing   = (fe_in.comparator != sign_ff);
  assign at_limit   = (nxt_disch == {charge_n_ff, 1'b0});
  assign run_tick   = ce & tick & ~force_zero;
  assign charge_end = run_tick & (state_ff == charge_phase) & nxt_timer[16];
  assign conv_done  = run_tick & (state_ff == discharge_phase) & (crossing | at_limit);
  assign xfer       = ce & new_ff & host_in.read_sel_n;
  assign ahb_take   = hsel & htrans[1] & hready;

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff    <= 2'h0;
      // idle pin levels, so that no false strobe edge follows reset
      host_q_ff <= 4'hE;
    end else if (ce) begin
      div_ff    <= div_ff + 2'h1;
      host_q_ff <= host_in;
    end
  end

  // comparator is looked at once per timebase count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comp_tb_ff <= 1'b0;
    end else if (ce && tick) begin
      comp_tb_ff <= fe_in.comparator;
    end
  end

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= settle_phase;
      timer_ff <= 17'h00000;
    end else if (ce) begin
      if (force_zero) begin
        state_ff <= zeroing_phase;
        timer_ff <= {1'b0, preset_ff, 8'h00};
      end else if (tick) begin
        case (state_ff)
          settle_phase: begin
            if (fe_in.comparator != comp_tb_ff) begin
              state_ff <= zeroing_phase;
              timer_ff <= {1'b0, preset_ff, 8'h00};
            end
          end
          zeroing_phase: begin
            if (nxt_timer[16]) begin
              state_ff <= charge_phase;
              timer_ff <= {1'b0, preset_ff, 8'h00};
            end else begin
              timer_ff <= nxt_timer;
            end
          end
          charge_phase: begin
            if (nxt_timer[16]) begin
              state_ff <= discharge_phase;
            end else begin
              timer_ff <= nxt_timer;
            end
          end
          discharge_phase: begin
            if (crossing || at_limit) begin
              state_ff <= settle_phase;
            end
          end
          default: state_ff <= settle_phase;
        endcase
      end
    end
  end

  // front end encoding: settle 00, zeroing 01, charge 10, discharge 11
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_out_ff <= '0;
    end else if (ce) begin
      phase_out_ff.phase_a <= (state_ff == charge_phase) | (state_ff == discharge_phase);
      phase_out_ff.phase_b <= (state_ff == zeroing_phase) | (state_ff == discharge_phase);
    end
  end

  // ----------------------------------------------------------------
  // discharge measurement and result
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sign_ff      <= 1'b0;
      disch_cnt_ff <= 18'h00000;
      charge_n_ff  <= 17'h00000;
      result_ff    <= 18'h00000;
      new_ff       <= 1'b0;
    end else if (ce) begin
      if (charge_end) begin
        sign_ff      <= fe_in.comparator;
        disch_cnt_ff <= 18'h00000;
        charge_n_ff  <= dsa_counts(preset_ff);
      end else if (run_tick && state_ff == discharge_phase) begin
        disch_cnt_ff <= nxt_disch;
      end
      if (conv_done) begin
        // a crossing in the same count as the limit still counts as in range
        result_ff <= crossing ? {1'b0, sign_ff, disch_cnt_ff[15:0]}
                              : {1'b1, sign_ff, nxt_disch[15:0]};
        new_ff    <= 1'b1;
      end else if (xfer) begin
        new_ff    <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial output side
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_data_ff <= 18'h00000;
      rdy_n_ff    <= 1'b1;
      shreg_ff    <= 18'h00000;
      oe_ff       <= 1'b0;
    end else if (ce) begin
      oe_ff <= ~host_in.read_sel_n;
      if (xfer) begin
        out_data_ff <= result_ff;
        rdy_n_ff    <= 1'b0;
      end else if (rd_fall) begin
        rdy_n_ff    <= 1'b1;
      end
      if (rd_fall) begin
        shreg_ff <= out_data_ff;
      end else if (!host_in.read_sel_n && sclk_fall) begin
        shreg_ff <= {shreg_ff[16:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // preset register: serial pins win over a bus write in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      preset_ff <= `DSA_PRESET_RST;
    end else if (ce) begin
      if (load_fall) begin
        preset_ff <= {host_in.serial_in, 7'h00};
      end else if (!host_in.preset_strobe_n && sclk_rise) begin
        preset_ff <= {preset_ff[6:0], host_in.serial_in};
      end else if (wr_pend_ff && wr_addr_ff == `DSA_OFS_PRESET) begin
        preset_ff <= hwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave: zero wait states, read data prepared in address phase
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff    <= 1'b0;
      wr_addr_ff    <= 8'h00;
      hrdata_ff     <= 32'h00000000;
      ctrl_force_ff <= 1'b0;
      hresp_ff      <= 1'b0;
      hreadyout_ff  <= 1'b0;
    end else if (ce) begin
      hreadyout_ff <= 1'b1;
      wr_pend_ff <= ahb_take & hwrite;
      wr_addr_ff <= haddr[7:0];
      hrdata_ff  <= (ahb_take && !hwrite) ? dsa_read_mux(haddr[7:0]) : 32'h00000000;
      if (wr_pend_ff && wr_addr_ff == `DSA_OFS_CTRL) begin
        ctrl_force_ff <= hwdata[`DSA_CTRL_FORCE_BIT];
      end
    end
  end

  assign hrdata           = hrdata_ff;
  assign hreadyout        = hreadyout_ff;
  assign hresp            = hresp_ff;
  assign serial_out       = shreg_ff[`DSA_RES_OVR_BIT];
  assign serial_out_oe    = oe_ff;
  assign result_ready_n   = rdy_n_ff;
  assign phase_out        = phase_out_ff;
  assign divided_timebase = div_ff[1];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // ticks since the last forced zeroing or the end of zeroing or charge, for the zeroing length check
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_ticks_ff <= 16'h0000;
    end else if (ce && tick) begin
      ph_ticks_ff <= (force_zero || nxt_timer[16]) ? 16'h0000 : ph_ticks_ff + 16'h0001;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_zero_len: assert property (run_tick && state_ff == zeroing_phase && nxt_timer[16]
    && timer_ff == nxt_timer - 17'h00001 && ph_ticks_ff != 16'h0000
    |-> 17'(ph_ticks_ff) + 17'h00001 == dsa_counts(preset_ff)) else $error("zeroing length");
  a_charge_len: assert property (charge_end |=> charge_n_ff == dsa_counts($past(preset_ff)))
    else $error("charge count not latched");
  a_disch_limit: assert property (state_ff == discharge_phase
    |-> disch_cnt_ff < {charge_n_ff, 1'b0}) else $error("discharge past limit");
  a_timebase_div: assert property (ce && tick |=> divided_timebase == 1'b0)
    else $error("timebase wrong phase");
  a_settle_wait: assert property (ce && state_ff == settle_phase && !force_zero
    && !(tick && fe_in.comparator != comp_tb_ff) |=> state_ff == settle_phase)
    else $error("settle left early");
  a_force_zeroing: assert property (ce && force_zero ##1 ce
    |=> !phase_out.phase_a && phase_out.phase_b) else $error("not held in zeroing");
  a_preset_top: assert property (ce && load_fall
    |=> preset_ff == {$past(host_in.serial_in), 7'h00}) else $error("preset default wrong");
  a_out_enable: assert property (ce |=> serial_out_oe == !$past(host_in.read_sel_n))
    else $error("serial output enable wrong");
  a_frame_load: assert property (ce && rd_fall |=> shreg_ff == $past(out_data_ff))
    else $error("frame not loaded");
  a_ovr_first: assert property (ce && rd_fall |=> serial_out == $past(out_data_ff[17]))
    else $error("overrange not first");
  a_hold_read: assert property (!host_in.read_sel_n |=> $stable(out_data_ff))
    else $error("result changed during read");
  a_ready_low: assert property (xfer
    |=> !result_ready_n && out_data_ff == $past(result_ff))
    else $error("result ready not asserted");

  c_overrange: cover property (conv_done && !crossing);
  c_in_range: cover property (conv_done && crossing);
  c_read_shift: cover property (rd_fall ##[1:20] (sclk_fall && !host_in.read_sel_n));

endmodule : dsa_ctrl

// [dsa_fe_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// dual-slope front end: integrator and comparator
// ----------------------------------------------------------------
module dsa_fe_model (
  // timing
  input  wire logic                    hclk,
  input  wire logic                    divided_timebase,
  // phase control and analog levels
  input  wire dsa_pkg::dsa_phase_out_t phase_out,
  input  int                           vin,
  input  int                           vref,
  // comparator
  output logic                         comparator
);
  import dsa_pkg::*;
  int   integ = 0;
  logic tb_q  = 1'b0;
  logic pos   = 1'b0;
  // stays hung in settle until a discharge has run, as the real part does
  logic ran   = 1'b0;
  assign comparator = (integ > 0);
  always @(posedge hclk) begin
    tb_q <= divided_timebase;
    if (divided_timebase && !tb_q) begin
      case (phase_out)
        2'h1: integ <= 0;
        2'h2: begin
          integ <= integ + vin;
          pos   <= (integ + vin > 0);
        end
        2'h3: begin
          integ <= pos ? integ - vref : integ + vref;
          ran   <= 1'b1;
        end
        default: if (ran) integ <= (integ > 0) ? -1 : 1;
      endcase
    end
  end
endmodule : dsa_fe_model

// [dual_slope_adc_serial_controller_bench.sv]
`timescale 1ns/1ps
module dual_slope_adc_serial_controller_bench;
  import dsa_pkg::*;
  // ----------------------------------------------------------------
  // pins and bookkeeping
  // ----------------------------------------------------------------
  logic           hclk = 1'b0;
  logic           hresetn = 1'b0;
  logic           hsel = 1'b0;
  logic [31:0]    haddr = 32'h0;
  logic [1:0]     htrans = 2'h0;
  logic           hwrite = 1'b0;
  logic [31:0]    hwdata = 32'h0;
  logic [31:0]    hrdata;
  logic           hreadyout, hresp, serial_out, serial_out_oe, result_ready_n, tb;
  logic           strobe = 1'b1, rsel_n = 1'b1, pstb_n = 1'b1, sin = 1'b0;
  logic           comp, allow_n = 1'b0, ce = 1'b1;
  dsa_phase_out_t ph;
  int             vin = 3, vref = 4, fails = 0, compares = 0, cyc = 0, n;
  logic [17:0]    fr;
  logic [31:0]    rd;

  always #50 hclk = ~hclk;

  dsa_ctrl i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .host_in({strobe, rsel_n, pstb_n, sin}), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .result_ready_n(result_ready_n),
    .fe_in({comp, allow_n}), .phase_out(ph), .divided_timebase(tb)
  );
  dsa_fe_model i_fe (
    .hclk(hclk), .divided_timebase(tb), .phase_out(ph), .vin(vin), .vref(vref),
    .comparator(comp)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic cy(input int k);
    repeat (k) @(posedge hclk);
  endtask : cy

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    // hsel stays up; an idle htrans keeps the slave quiet between calls
  endtask : ahb

  task automatic load(input logic b, input logic [7:0] v, input int nb);
    sin    <= b;
    pstb_n <= 1'b0;
    cy(3);
    check("load zeroing", ph, 2'h1);
    for (int i = nb - 1; i >= 0; i--) begin
      sin    <= v[i];
      strobe <= 1'b0;
      cy(2);
      strobe <= 1'b1;
      cy(2);
    end
    pstb_n <= 1'b1;
    cy(2);
    ahb(1'b0, 32'h8, 32'h0);
  endtask : load

  task automatic frame(input int w);
    rsel_n <= 1'b0;
    cy(3);
    check("oe on", serial_out_oe, 1'b1);
    check("ready cleared", result_ready_n, 1'b1);
    fr[17] = serial_out;
    // two strobes past the frame must give zeros
    for (int i = 18; i >= 0; i--) begin
      strobe <= 1'b0;
      cy(w + 1);
      if (i >= 2) fr[i-2] = serial_out;
      else check("excess bit", serial_out, 1'b0);
      strobe <= 1'b1;
      cy(w);
    end
    rsel_n <= 1'b1;
    cy(3);
    check("oe off", serial_out_oe, 1'b0);
  endtask : frame

  task automatic plen(input logic [1:0] p);
    while (ph === p) @(posedge hclk);
    while (ph !== p) @(posedge hclk);
    n = 0;
    while (ph === p) begin
      n++;
      @(posedge hclk);
    end
  endtask : plen

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_powerup();
    check("hung settle", ph, 2'h0);
    check("oe idle", serial_out_oe, 1'b0);
    ahb(1'b0, 32'h0, 32'h0);
    check("status", rd, 32'h41);
    ahb(1'b0, 32'h8, 32'h0);
    check("preset rst", rd, 32'h80);
    ahb(1'b0, 32'h10, 32'h0);
    check("unmapped", rd, 32'h0);
    check("okay resp", hresp, 1'b0);
    $display("test powerup done");
  endtask : t_powerup

  task automatic t_preset();
    load(1'b0, 8'h00, 0);
    check("preset low", rd, 32'h00);
    load(1'b1, 8'h00, 0);
    check("preset high", rd, 32'h80);
    load(1'b0, 8'hFE, 8);
    check("preset shift", rd, 32'hFE);
    load(1'b1, 8'hFF, 8);
    check("preset ff", rd, 32'hFF);
    $display("test preset done");
  endtask : t_preset

  task automatic t_timing();
    n = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge hclk);
      if (tb && !i_fe.tb_q) n++;
    end
    check("timebase rises", n, 10);
    rsel_n <= 1'b0;
    cy(3);
    repeat (3) begin
      strobe <= 1'b0;
      cy(2);
      strobe <= 1'b1;
      cy(2);
    end
    rsel_n <= 1'b1;
    plen(2'h2);
    check("charge len", n, 1024);
    plen(2'h1);
    check("zeroing len", n, 1024);
    $display("test timing done");
  endtask : t_timing

  task automatic t_force();
    allow_n <= 1'b1;
    cy(3);
    // bus writes to the preset only while the timer is held in reload
    ahb(1'b1, 32'h8, 32'h40);
    ahb(1'b0, 32'h8, 32'h0);
    check("preset write", rd, 32'h40);
    ahb(1'b1, 32'h8, 32'hFF);
    ce <= 1'b0;
    cy(2);
    n = tb;
    cy(9);
    check("ce freeze", tb, n);
    ce <= 1'b1;
    n = 0;
    repeat (2000) begin
      if (ph !== 2'h1) n++;
      @(posedge hclk);
    end
    check("allow hold", n, 0);
    allow_n <= 1'b0;
    ahb(1'b1, 32'hC, 32'h1);
    cy(3);
    check("ctrl zeroing", ph, 2'h1);
    ahb(1'b0, 32'hC, 32'h0);
    check("ctrl read", rd, 32'h1);
    ahb(1'b1, 32'hC, 32'h0);
    $display("test force done");
  endtask : t_force

  task automatic conv(input int vi, input int vr, input int m, input logic ov, input int w);
    int d;
    while (ph !== 2'h1) @(posedge hclk);
    vin <= vi;
    vref <= vr;
    rsel_n <= 1'b0;
    cy(3);
    rsel_n <= 1'b1;
    while (result_ready_n !== 1'b0) @(posedge hclk);
    cy(2);
    frame(w);
    d = int'(fr[15:0]) - m;
    check("ovr", fr[17], ov);
    if (!ov) check("sign", fr[16], vi > 0);
    if (!ov) check("mag", (^fr !== 1'bx) && d >= -2 && d <= 2, 1'b1);
    ahb(1'b0, 32'h4, 32'h0);
    check("result reg", rd, {14'h0, fr});
    $display("test conv %0d done", vi);
  endtask : conv

  task automatic t_hold();
    while (ph !== 2'h3) @(posedge hclk);
    rsel_n <= 1'b0;
    while (ph !== 2'h0) @(posedge hclk);
    cy(8);
    check("ready held", result_ready_n, 1'b1);
    rsel_n <= 1'b1;
    cy(4);
    check("ready after", result_ready_n, 1'b0);
    $display("test hold done");
  endtask : t_hold

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      fails++;
      complete_run();
    end
  end

  initial begin
    cy(20);
    hresetn <= 1'b1;
    cy(200);
    t_powerup();
    t_preset();
    t_timing();
    t_force();
    conv(3, 4, 192, 1'b0, 2);
    conv(-1, 4, 64, 1'b0, 5);
    conv(15, 8, 480, 1'b0, 1);
    conv(9, 4, 512, 1'b1, 3);
    t_hold();
    complete_run();
  end
endmodule : dual_slope_adc_serial_controller_bench
